// ### logic/apes_params.svh
// Named constants of the axis error and stop block: axis count, code width,
// recorded error codes and reset values.
// Assumes inclusion by its bare name from the package and the design files.
`ifndef APES_PARAMS_SVH
`define APES_PARAMS_SVH

// Number of servo axes handled by the block.
`define APES_AXES 8
// Width of one recorded error code.
`define APES_CODE_W 8
// Width of the per-axis control mode code.
`define APES_MODE_W 4
// Two-flop synchroniser depth is fixed; this is the reset level of its stages.
`define APES_SYNC_RST 1'b0

// Error code recorded after reset, meaning no error.
`define APES_CODE_NONE 8'h00
// Ready flag cleared while an axis starts (decimal 200).
`define APES_ERR_READY_START 8'hc8
// Ready flag cleared during zero return (decimal 201).
`define APES_ERR_READY_ZR 8'hc9
// Stop command during zero return (decimal 202).
`define APES_ERR_STOP_ZR 8'hca
// Quick-stop command during zero return (decimal 203).
`define APES_ERR_QUICK_ZR 8'hcb
// Ready flag set again while still decelerating (decimal 204).
`define APES_ERR_READY_EARLY 8'hcc
// Keyboard emergency stop during zero return (decimal 206).
`define APES_ERR_KEY_ESTOP 8'hce
// Command position beyond the stroke limit (decimal 207).
`define APES_ERR_STROKE 8'hcf

`endif

// ### logic/apes_pkg.sv
// Types shared by the axis error and stop block.
// Assumes apes_params.svh is on the include path.
`include "apes_params.svh"

package apes_pkg;

  // Control mode of one axis, as presented by the motion sequencer.
  typedef enum logic [`APES_MODE_W-1:0] {
    apes_mode_pos    = 4'h0,
    apes_mode_incr   = 4'h1,
    apes_mode_vel    = 4'h2,
    apes_mode_vpos   = 4'h3,
    apes_mode_vchg   = 4'h4,
    apes_mode_cv     = 4'h5,
    apes_mode_jog    = 4'h6,
    apes_mode_mpg    = 4'h7,
    apes_mode_zr     = 4'h8,
    apes_mode_follow = 4'h9
  } apes_mode_t;

  // Recorded error code of one axis.
  typedef logic [`APES_CODE_W-1:0] apes_code_t;

endpackage : apes_pkg

// ### logic/apes_axis_if.sv
// Interface between the block top and one per-axis error and stop unit.
// Assumes all signals are synchronous to the block clock.
`include "apes_params.svh"

interface apes_axis_if;
  import apes_pkg::*;

  logic       ready_fall;  // Ready flag cleared this cycle.
  logic       ready_rise;  // Ready flag set this cycle.
  logic       estop;       // Keyboard emergency stop level.
  logic       stop_cmd;    // Synchronised stop command level.
  logic       quick_cmd;   // Synchronised quick-stop command level.
  logic       busy;        // Axis in motion.
  logic       starting;    // Axis starting on a sequencer request.
  logic       stopped;     // Axis has come to rest.
  logic       stroke_hit;  // Stroke-limit error applies to this axis.
  apes_mode_t mode;        // Current control mode.
  apes_code_t code;        // Held error code.
  logic       code_new;    // High in each cycle after a store condition held; stays high while the cause persists.
  logic       decel;       // Decelerating stop in progress.
  logic       immed;       // Immediate stop in progress.
  logic       rdecel;      // Decelerating because the ready flag fell.

  modport top  (output ready_fall, ready_rise, estop, stop_cmd, quick_cmd, busy, starting, stopped,
                stroke_hit, mode, input code, code_new, decel, immed, rdecel);
  modport axis (input ready_fall, ready_rise, estop, stop_cmd, quick_cmd, busy, starting, stopped,
                stroke_hit, mode, output code, code_new, decel, immed, rdecel);
endinterface : apes_axis_if

// ### logic/apes_axis.sv
// Per-axis error recording and stop request unit.
// Assumes synchronised inputs from the block top through apes_axis_if.
`include "apes_params.svh"

module apes_axis
  import apes_pkg::*;
(
  input wire logic  clk,
  input wire logic  arst_n,
  apes_axis_if.axis ax
);

  logic       stop_prev_reg;
  logic       quick_prev_reg;
  apes_code_t code_reg;
  apes_code_t code_next;
  logic       new_reg;
  logic       decel_reg;
  logic       immed_reg;
  logic       rdecel_reg;
  logic       hit;
  logic       decel_req;
  logic       immed_req;
  logic       rdecel_req;
  logic       stop_rise;
  logic       quick_rise;
  logic       zr_busy;
  logic       stroke_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Event decode.
  assign stop_rise   = ax.stop_cmd & ~stop_prev_reg;
  assign quick_rise  = ax.quick_cmd & ~quick_prev_reg;
  assign zr_busy     = ax.busy & (ax.mode == apes_mode_zr);
  assign stroke_mode = (ax.mode == apes_mode_pos) | (ax.mode == apes_mode_vchg) | (ax.mode == apes_mode_cv) |
                       (ax.mode == apes_mode_jog) | (ax.mode == apes_mode_follow);

  // Priority encoder: immediate stops win over decelerating ones.
  always_comb begin
    code_next  = code_reg;
    hit        = 1'b0;
    decel_req  = 1'b0;
    immed_req  = 1'b0;
    rdecel_req = 1'b0;
    // RULE6 and RULE4 immediate stops.
    if (zr_busy && (ax.estop || quick_rise)) begin
      hit       = 1'b1;
      immed_req = 1'b1;
      code_next = ax.estop ? `APES_ERR_KEY_ESTOP : `APES_ERR_QUICK_ZR;
    // RULE3 stop ends return.
    end else if (zr_busy && stop_rise) begin
      hit       = 1'b1;
      decel_req = 1'b1;
      code_next = `APES_ERR_STOP_ZR;
    // RULE2 ready drop halts return.
    end else if (zr_busy && ax.ready_fall) begin
      hit        = 1'b1;
      decel_req  = 1'b1;
      rdecel_req = 1'b1;
      code_next  = `APES_ERR_READY_ZR;
    // RULE1 ready drop at start.
    end else if (ax.starting && (ax.mode != apes_mode_zr) && ax.ready_fall) begin
      hit        = 1'b1;
      decel_req  = 1'b1;
      rdecel_req = 1'b1;
      code_next  = `APES_ERR_READY_START;
    // RULE7 stroke limit stop.
    end else if (ax.stroke_hit && stroke_mode) begin
      hit       = 1'b1;
      decel_req = 1'b1;
      code_next = `APES_ERR_STROKE;
    // RULE5 early ready recorded.
    end else if (ax.ready_rise && rdecel_reg) begin
      hit       = 1'b1;
      code_next = `APES_ERR_READY_EARLY;
    end
  end

  // Command edge history.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_prev_reg  <= 1'b0;
      quick_prev_reg <= 1'b0;
    end else begin
      stop_prev_reg  <= ax.stop_cmd;
      quick_prev_reg <= ax.quick_cmd;
    end
  end

  // RULE13 held error code.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      code_reg <= `APES_CODE_NONE;
      new_reg  <= 1'b0;
    end else begin
      code_reg <= code_next;
      new_reg  <= hit;
    end
  end

  // Stop requests hold until the axis rests; a new request wins over the clear.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      decel_reg  <= 1'b0;
      immed_reg  <= 1'b0;
      rdecel_reg <= 1'b0;
    end else begin
      if (immed_req) begin
        immed_reg <= 1'b1;
        decel_reg <= 1'b0;
      end else if (decel_req) begin
        decel_reg <= ~immed_reg;
      end else if (ax.stopped) begin
        decel_reg <= 1'b0;
        immed_reg <= 1'b0;
      end
      if (rdecel_req) begin
        rdecel_reg <= 1'b1;
      end else if (ax.stopped) begin
        rdecel_reg <= 1'b0;
      end
    end
  end

  assign ax.code     = code_reg;
  assign ax.code_new = new_reg;
  assign ax.decel    = decel_reg;
  assign ax.immed    = immed_reg;
  assign ax.rdecel   = rdecel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  sequence s_zr_quick;
    zr_busy && quick_rise && !ax.estop;
  endsequence
  sequence s_immed_code;
    (code_reg == `APES_ERR_QUICK_ZR) && immed_reg && !decel_reg;
  endsequence

  property p_start_drop;
    @(posedge clk) disable iff (!arst_n)
      ax.starting && (ax.mode != apes_mode_zr) && ax.ready_fall |=>
        code_reg == `APES_ERR_READY_START && (decel_reg != $past(immed_reg));
  endproperty
  a_start_drop: assert property (p_start_drop) else $error("ready drop at start not coded"); // RULE1

  property p_zr_drop;
    @(posedge clk) disable iff (!arst_n)
      zr_busy && ax.ready_fall && !ax.estop && !quick_rise && !stop_rise |=> code_reg == `APES_ERR_READY_ZR;
  endproperty
  a_zr_drop: assert property (p_zr_drop) else $error("ready drop in zero return not coded"); // RULE2

  property p_zr_stop;
    @(posedge clk) disable iff (!arst_n)
      zr_busy && stop_rise && !ax.estop && !quick_rise |=>
        code_reg == `APES_ERR_STOP_ZR && (decel_reg != $past(immed_reg)) && new_reg;
  endproperty
  a_zr_stop: assert property (p_zr_stop) else $error("stop in zero return not coded"); // RULE3

  property p_zr_quick;
    @(posedge clk) disable iff (!arst_n) s_zr_quick |=> s_immed_code;
  endproperty
  a_zr_quick: assert property (p_zr_quick) else $error("quick stop not immediate"); // RULE4

  property p_estop;
    @(posedge clk) disable iff (!arst_n)
      zr_busy && ax.estop |=> code_reg == `APES_ERR_KEY_ESTOP ##0 immed_reg ##1 (immed_reg || $past(ax.stopped));
  endproperty
  a_estop: assert property (p_estop) else $error("emergency stop not immediate"); // RULE6

  property p_stroke;
    @(posedge clk) disable iff (!arst_n)
      ax.stroke_hit && stroke_mode && !ax.ready_fall && !zr_busy |=> code_reg == `APES_ERR_STROKE;
  endproperty
  a_stroke: assert property (p_stroke) else $error("stroke error not coded"); // RULE7

  property p_code_hold;
    @(posedge clk) disable iff (!arst_n) !$stable(code_reg) |-> new_reg;
  endproperty
  a_code_hold: assert property (p_code_hold) else $error("error code changed without a store"); // RULE13

endmodule : apes_axis

// ### logic/apes_top.sv
// Top of the axis positioning error and stop block: input synchronisers,
// ready flag handling, stroke error spreading and one unit per axis.
// Assumes a single 10 MHz clock; every input may come from another domain.
// Summary of operation
// RULE1: Ready drop while starting: code 200, decelerate.
// RULE2: Ready drop in zero return: code 201, halt.
// RULE3: Stop command in zero return: code 202.
// RULE4: Quick stop in zero return: code 203, immediate.
// RULE5: Ready set while decelerating: code 204, ignored.
// RULE6: Keyboard emergency stop in zero return: 206, immediate.
// RULE7: Stroke limit exceeded: code 207, decelerate; the code records it only in the pos, vchg, cv, jog and follow modes.
// RULE8: Circular stores offender only; linear stores all.
// RULE9: Sequencer restores ready or commands before retrying.
// RULE10: Dog return retried after moving back before dog.
// RULE11: Count return retried directly if dog active.
// RULE12: Sequencer sets ready only after all stopped.
// RULE13: Per-axis code held until overwritten or reset.
`include "apes_params.svh"

module apes_top
  import apes_pkg::*;
(
  input  wire logic                                       clk,
  input  wire logic                                       arst_n,
  input  wire logic                                       controller_ready_flag,
  input  wire logic                                       key_emergency_stop,
  input  wire logic                                       interp_linear,
  input  wire logic [`APES_AXES-1:0]                      axis_stop_command,
  input  wire logic [`APES_AXES-1:0]                      axis_quick_stop_command,
  input  wire logic [`APES_AXES-1:0]                      axis_busy,
  input  wire logic [`APES_AXES-1:0]                      axis_starting,
  input  wire logic [`APES_AXES-1:0]                      axis_stopped,
  input  wire logic [`APES_AXES-1:0]                      stroke_exceed,
  input  wire logic [`APES_AXES-1:0]                      interp_member,
  input  wire logic [`APES_AXES-1:0][`APES_MODE_W-1:0]    axis_mode,
  output logic      [`APES_AXES-1:0][`APES_CODE_W-1:0]    error_code,
  output logic      [`APES_AXES-1:0]                      error_new,
  output logic      [`APES_AXES-1:0]                      axis_decel_stop,
  output logic      [`APES_AXES-1:0]                      axis_immediate_stop,
  output logic                                            controller_ready_accepted,
  output logic                                            ready_set_ignored
);

  localparam int N  = `APES_AXES;
  localparam int SW = 3 + 7 * N + `APES_MODE_W * N;

  logic [SW-1:0]                      sync_in;
  logic [SW-1:0]                      sync1_reg;
  logic [SW-1:0]                      sync2_reg;
  logic                               estop_s;
  logic                               ready_s;
  logic                               lin_s;
  logic [N-1:0]                       stop_s;
  logic [N-1:0]                       quick_s;
  logic [N-1:0]                       busy_s;
  logic [N-1:0]                       start_s;
  logic [N-1:0]                       stopped_s;
  logic [N-1:0]                       stroke_s;
  logic [N-1:0]                       member_s;
  logic [N-1:0][`APES_MODE_W-1:0]     mode_s;
  logic                               ready_prev_reg;
  logic                               ready_rise;
  logic                               ready_fall;
  logic                               lin_exceed;
  logic [N-1:0]                       hit;
  logic [N-1:0]                       rdecel;
  logic                               any_rdecel;
  logic                               accepted_reg;
  logic                               ignored_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers: the first stage feeds only the second.
  assign sync_in = {key_emergency_stop, controller_ready_flag, interp_linear, axis_stop_command,
                    axis_quick_stop_command, axis_busy, axis_starting, axis_stopped, stroke_exceed,
                    interp_member, axis_mode};

  // Two-flop capture of every outside input.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_reg <= {SW{`APES_SYNC_RST}};
      sync2_reg <= {SW{`APES_SYNC_RST}};
    end else begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
    end
  end

  // Unpacking of the synchronised vector.
  assign {estop_s, ready_s, lin_s, stop_s, quick_s, busy_s, start_s, stopped_s, stroke_s,
          member_s, mode_s} = sync2_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Ready flag edges.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ready_prev_reg <= 1'b0;
    end else begin
      ready_prev_reg <= ready_s;
    end
  end

  assign ready_rise = ready_s & ~ready_prev_reg;
  assign ready_fall = ~ready_s & ready_prev_reg;
  assign any_rdecel = |rdecel;

  // RULE5 ignore early ready.
  // RULE12 relies on ordered setting.
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      accepted_reg <= 1'b0;
      ignored_reg  <= 1'b0;
    end else begin
      ignored_reg <= ready_rise & any_rdecel;
      if (ready_fall) begin
        accepted_reg <= 1'b0;
      end else if (ready_rise) begin
        accepted_reg <= ~any_rdecel;
      end
    end
  end

  assign controller_ready_accepted = accepted_reg;
  assign ready_set_ignored         = ignored_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Stroke error spreading over an interpolation group.
  // RULE8 circular versus linear.
  assign lin_exceed = |(stroke_s & member_s);

  // One error and stop unit per axis.
  for (genvar i = 0; i < N; i++) begin : g_axis
    apes_axis_if u_if ();

    assign hit[i]            = stroke_s[i] | (lin_s & member_s[i] & lin_exceed);
    assign u_if.ready_fall   = ready_fall;
    assign u_if.ready_rise   = ready_rise;
    assign u_if.estop        = estop_s;
    assign u_if.stop_cmd     = stop_s[i];
    assign u_if.quick_cmd    = quick_s[i];
    assign u_if.busy         = busy_s[i];
    assign u_if.starting     = start_s[i];
    assign u_if.stopped      = stopped_s[i];
    assign u_if.stroke_hit   = hit[i];
    assign u_if.mode         = apes_mode_t'(mode_s[i]);
    assign rdecel[i]         = u_if.rdecel;
    assign error_code[i]     = u_if.code;
    assign error_new[i]      = u_if.code_new;
    assign axis_decel_stop[i]     = u_if.decel;
    assign axis_immediate_stop[i] = u_if.immed;

    apes_axis u_axis (
      .clk    (clk),
      .arst_n (arst_n),
      .ax     (u_if)
    );

    // RULE8 circular stores offender.
    property p_circ_only;
      @(posedge clk) disable iff (!arst_n) !lin_s && !stroke_s[i] |-> !hit[i];
    endproperty
    a_circ_only: assert property (p_circ_only) else $error("stroke error spread in circular mode"); // RULE8

    property p_lin_all;
      @(posedge clk) disable iff (!arst_n)
        lin_s && member_s[i] && lin_exceed && !ready_fall &&
        ((mode_s[i] == apes_mode_pos) || (mode_s[i] == apes_mode_cv))
        |=> error_code[i] == `APES_ERR_STROKE && axis_decel_stop[i];
    endproperty
    a_lin_all: assert property (p_lin_all) else $error("linear group axis not coded"); // RULE8
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks on the ready flag handling.
  sequence s_early_ready;
    ready_rise && any_rdecel;
  endsequence

  property p_early_ready;
    @(posedge clk) disable iff (!arst_n) s_early_ready |=> ready_set_ignored && !controller_ready_accepted;
  endproperty
  a_early_ready: assert property (p_early_ready) else $error("early ready not ignored"); // RULE5

  property p_ready_ok;
    @(posedge clk) disable iff (!arst_n)
      ready_rise && !any_rdecel |=> controller_ready_accepted && !ready_set_ignored;
  endproperty
  a_ready_ok: assert property (p_ready_ok) else $error("ready not accepted after stop"); // RULE5

  property p_ready_drop;
    @(posedge clk) disable iff (!arst_n) ready_fall |=> !controller_ready_accepted;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready still accepted after drop"); // RULE1

  property p_ignore_pulse;
    @(posedge clk) disable iff (!arst_n) ready_set_ignored |=> !ready_set_ignored;
  endproperty
  a_ignore_pulse: assert property (p_ignore_pulse) else $error("ignore flag longer than a cycle"); // RULE5

endmodule : apes_top

// ### verif/apes_seq_model.sv
// Sequence program model: drives the ready flag and the per-axis stop commands.
// Assumes its tasks are called just after a rising clock edge.
module apes_seq_model (
  input  wire logic       clk,
  input  wire logic [7:0] axis_stopped,
  output logic            controller_ready_flag,
  output logic      [7:0] axis_stop_command,
  output logic      [7:0] axis_quick_stop_command
);
  timeunit 1ns;
  timeprecision 100ps;

  // Raised when the wait for rest ran out before the ready flag was set.
  bit wait_expired;

  ////////////////////////////////////////
  // Everything is released at time zero.
  initial begin
    controller_ready_flag   = 1'b0;
    axis_stop_command       = 8'h00;
    axis_quick_stop_command = 8'h00;
  end

  ////////////////////////////////////////
  // ready after rest
  // Waits up to 200 cycles for all axes at rest; an early set is made when asked for or when that wait runs out.
  task automatic set_ready(input bit early);
    int n;
    n = 0;
    while (!early && (axis_stopped !== 8'hff) && n < 200) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n >= 200) begin
      wait_expired = 1'b1;
    end
    controller_ready_flag = 1'b1;
  endtask

  // Clears the ready flag.
  task automatic drop_ready();
    controller_ready_flag = 1'b0;
  endtask

  // Raises stop commands on the axes in the mask.
  task automatic set_stop(input logic [7:0] mask);
    axis_stop_command = axis_stop_command | mask;
  endtask

  // Raises quick-stop commands on the axes in the mask.
  task automatic set_quick(input logic [7:0] mask);
    axis_quick_stop_command = axis_quick_stop_command | mask;
  endtask

  // release before retry
  // Both commands are lowered before any zero return is retried.
  task automatic release_cmds();
    axis_stop_command       = 8'h00;
    axis_quick_stop_command = 8'h00;
  endtask
endmodule // apes_seq_model

// ### verif/apes_top_tb.sv
// Self-checking testbench of the axis error and stop block.
// Assumes the design files and apes_seq_model are compiled before it.
module apes_top_tb
  import apes_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;

  logic            clk;
  logic            arst_n;
  logic            key_emergency_stop;
  logic            interp_linear;
  logic [7:0]      busy;
  logic [7:0]      starting;
  logic [7:0]      stopped;
  logic [7:0]      stroke;
  logic [7:0]      member;
  logic [7:0][3:0] mode;
  logic            ready;
  logic [7:0]      stop_cmd;
  logic [7:0]      quick_cmd;
  logic [7:0][7:0] code;
  logic [7:0]      new_code;
  logic [7:0]      decel;
  logic [7:0]      immed;
  logic            accepted;
  logic            ignored;
  int              n_mismatch;
  int              samples_checked;

  apes_top dut (.clk(clk), .arst_n(arst_n), .controller_ready_flag(ready), .key_emergency_stop(key_emergency_stop),
    .interp_linear(interp_linear), .axis_stop_command(stop_cmd), .axis_quick_stop_command(quick_cmd),
    .axis_busy(busy), .axis_starting(starting), .axis_stopped(stopped), .stroke_exceed(stroke),
    .interp_member(member), .axis_mode(mode), .error_code(code), .error_new(new_code),
    .axis_decel_stop(decel), .axis_immediate_stop(immed), .controller_ready_accepted(accepted),
    .ready_set_ignored(ignored));

  apes_seq_model seq (.clk(clk), .axis_stopped(stopped), .controller_ready_flag(ready),
    .axis_stop_command(stop_cmd), .axis_quick_stop_command(quick_cmd));

  ////////////////////////////////////////
  // Free-running 10 MHz clock.
  always #50 clk = ~clk;

  // Counts a comparison and reports a difference at once.
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Waits n rising edges and lands just after the last one.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  // Puts one axis in motion in the given mode.
  task automatic move(input int a, input logic [3:0] m);
    busy[a]    = 1'b1;
    stopped[a] = 1'b0;
    mode[a]    = m;
  endtask

  // Brings every axis to rest and lets stop requests clear.
  // Parking in positioning mode stands for moving back before the dog.
  // park before retry
  task automatic idle();
    seq.release_cmds();
    busy     = 8'h00;
    starting = 8'h00;
    stroke   = 8'h00;
    member   = 8'h00;
    stopped  = 8'hff;
    mode     = '0;
    tick(5);
  endtask

  // Gives the ready flag a fresh rise with all axes at rest.
  task automatic rearm();
    seq.drop_ready();
    tick(4);
    seq.set_ready(1'b0);
    tick(4);
    chk("ready wait expired", 8'h00, {7'h00, seq.wait_expired});
    chk("ready accepted", 8'h01, {7'h00, accepted});
  endtask

  ////////////////////////////////////////
  // Ready drop while starting, then an early set while decelerating.
  task automatic t_ready_start();
    move(1, apes_mode_pos);
    starting[1] = 1'b1;
    seq.drop_ready();
    tick(4);
    chk("code 1", 8'hc8, code[1]);
    chk("decel", 8'h02, decel);
    chk("accepted", 8'h00, {7'h00, accepted});
    seq.set_ready(1'b1);
    tick(3);
    chk("code 1 early", 8'hcc, code[1]);
    chk("ignored", 8'h01, {7'h00, ignored});
    tick(2);
    chk("accepted kept low", 8'h00, {7'h00, accepted});
    stopped[1] = 1'b1;
    tick(4);
    chk("decel cleared", 8'h00, decel);
    idle();
    rearm();
  endtask

  // Ready drop during zero return.
  task automatic t_ready_zr();
    move(2, apes_mode_zr);
    seq.drop_ready();
    tick(4);
    chk("code 2", 8'hc9, code[2]);
    chk("decel zr", 8'h04, decel);
    idle();
    rearm();
  endtask

  // Stop command in zero return and outside it; code is held afterwards.
  task automatic t_stop_zr();
    move(0, apes_mode_zr);
    move(4, apes_mode_pos);
    seq.set_stop(8'h11);
    tick(3);
    chk("code 0", 8'hca, code[0]);
    chk("new stop", 8'h01, new_code);
    chk("decel stop", 8'h01, decel);
    chk("code 4", 8'h00, code[4]);
    idle();
    tick(10);
    chk("code 0 held", 8'hca, code[0]);
  endtask

  // Quick stop in zero return is immediate and lasts until rest.
  task automatic t_quick_zr();
    move(0, apes_mode_zr);
    seq.set_quick(8'h01);
    tick(4);
    chk("code 0 quick", 8'hcb, code[0]);
    chk("immed", 8'h01, immed);
    chk("no decel", 8'h00, decel);
    stopped[0] = 1'b1;
    tick(4);
    chk("immed cleared", 8'h00, immed);
    idle();
  endtask

  // Keyboard emergency stop hits zero return axes only.
  task automatic t_estop();
    move(5, apes_mode_zr);
    move(6, apes_mode_jog);
    key_emergency_stop = 1'b1;
    tick(4);
    chk("code 5", 8'hce, code[5]);
    chk("immed estop", 8'h20, immed);
    chk("code 6", 8'h00, code[6]);
    key_emergency_stop = 1'b0;
    idle();
  endtask

  // Stroke limit across every mode but zero return.
  task automatic t_stroke();
    logic [7:0] exp;
    for (int m = 0; m < 10; m++) begin
      if (m != 8) begin
        exp = (m == 0 || m == 4 || m == 5 || m == 6 || m == 9) ? 8'h80 : 8'h00;
        move(7, m[3:0]);
        stroke[7] = 1'b1;
        tick(4);
        chk("new stroke", exp, new_code);
        stroke[7]  = 1'b0;
        stopped[7] = 1'b1;
        tick(4);
      end
    end
    chk("code 7", 8'hcf, code[7]);
    idle();
  endtask

  // Circular stores the offender only; linear stores all members.
  task automatic t_interp();
    for (int a = 0; a < 4; a++) begin
      move(a, apes_mode_pos);
    end
    member        = 8'h07;
    interp_linear = 1'b0;
    tick(3);
    stroke[1] = 1'b1;
    tick(4);
    chk("new circular", 8'h02, new_code);
    stroke[1]     = 1'b0;
    interp_linear = 1'b1;
    tick(4);
    stroke[1] = 1'b1;
    tick(4);
    chk("new linear", 8'h07, new_code);
    idle();
  endtask

  // Prints the verdict and ends the run.
  task automatic stop_test();
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////
  // Cuts a hang short long after the tests should have ended.
  initial begin
    #(3000 * 100);
    n_mismatch++;
    stop_test();
  end

  // Reset, then every scenario in turn.
  initial begin
    clk                = 1'b0;
    arst_n             = 1'b0;
    key_emergency_stop = 1'b0;
    interp_linear      = 1'b0;
    busy               = 8'h00;
    starting           = 8'h00;
    stopped            = 8'hff;
    stroke             = 8'h00;
    member             = 8'h00;
    mode               = '0;
    n_mismatch         = 0;
    samples_checked    = 0;
    tick(8);
    arst_n = 1'b1;
    tick(1);
    for (int a = 0; a < 8; a++) begin
      chk("reset code", 8'h00, code[a]);
    end
    chk("reset new", 8'h00, new_code);
    rearm();
    t_ready_start();
    t_ready_zr();
    t_stop_zr();
    t_quick_zr();
    t_estop();
    t_stroke();
    t_interp();
    stop_test();
  end
endmodule // apes_top_tb
